//--- design/pphp_fifo.sv
// parameterised receive fifo with valid/ready on both sides
// assumes a single clock; full and empty are exact
module pphp_fifo #(
    parameter int unsigned W = 11,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;

    wire do_wr = in_valid_i && in_ready_o;
    wire do_rd = out_valid_o && out_ready_i;

    // full only when all DEPTH places hold a word
    assign in_ready_o = count_o < (AW+1)'(DEPTH);
    assign out_valid_o = count_o != '0;
    assign out_data_o = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (en_i && do_wr) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count_o <= '0;
        end else if (en_i) begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count_o <= count_o + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule

//--- design/pphp_pkg.sv
// package for the printer parallel host port: modes, widths, timing, carriers
// assumes a 25 MHz system clock; no software-visible registers
package pphp_pkg;

    // ------------------------------------------------------------
    // interface modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_COMPAT = 2'b00,
        MODE_NIBBLE = 2'b01,
        MODE_ECP    = 2'b10
    } pphp_mode_e;

    // ------------------------------------------------------------
    // receive buffer size selection
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BUF_100K = 2'b00,
        BUF_512K = 2'b01,
        BUF_1M   = 2'b10,
        BUF_AUTO = 2'b11
    } pphp_bufsel_e;

    localparam int unsigned BUF_100K_BYTES = 102400;
    localparam int unsigned BUF_512K_BYTES = 524288;
    localparam int unsigned BUF_1M_BYTES = 1048576;

    // ------------------------------------------------------------
    // word widths per mode
    // ------------------------------------------------------------
    localparam int unsigned WORD_W = 9;
    localparam int unsigned COMPAT_BITS = 8;
    localparam int unsigned NIBBLE_BITS = 4;
    localparam int unsigned ECP_BITS = 9;
    localparam int unsigned FIFO_DEPTH = 8;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned ACK_PULSE_NS = 1000;
    localparam int unsigned ACK_CYCLES =
        (ACK_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;

    // one received word: data, ecp command flag, mode it arrived in
    typedef struct packed {
        logic [WORD_W-1:0] data;
        logic [1:0] mode;
    } pphp_word_s;

    localparam int unsigned WORD_S_W = WORD_W + 2;

    // status returned to the host
    typedef struct packed {
        logic ack_n;
        logic busy;
        logic paper_end;
        logic select;
        logic fault_n;
    } pphp_status_s;

endpackage

//--- design/pphp_port.sv
// printer-side parallel host port: strobe capture, mode switch, status lines
// assumes host pins are asynchronous; print engine drains words from WORD_* handshake

module pphp_port #(
    parameter int unsigned FIFO_D = pphp_pkg::FIFO_DEPTH
) (
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    // host pins
    input wire logic STROBE_N_I,
    input wire logic [7:0] DATA_I,
    input wire logic AUTOFEED_N_I,
    input wire logic SELECT_IN_N_I,
    input wire logic INIT_N_I,
    output logic ACK_N_O,
    output logic BUSY_O,
    output logic PAPER_END_O,
    output logic SELECT_O,
    output logic FAULT_N_O,
    // printer controls
    input wire logic ONLINE_I,
    input wire logic PAPER_OUT_I,
    input wire logic ALARM_I,
    input wire logic PRINTING_I,
    input wire logic FUNC_DONE_I,
    input wire logic INIT_ENABLE_I,
    input wire logic [1:0] BUF_SEL_I,
    input wire logic [20:0] BUF_FREE_I,
    // word stream to the print engine
    output logic WORD_VALID_O,
    input wire logic WORD_READY_I,
    output logic [pphp_pkg::WORD_S_W-1:0] WORD_O,
    output logic [1:0] MODE_O,
    output logic INIT_REQ_O
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [11:0] pins_q;
    pphp_sync #(.W(12)) u_sync (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RST_N_I),
        .en_i(CE_I),
        .pin_i({STROBE_N_I, AUTOFEED_N_I, SELECT_IN_N_I, INIT_N_I, DATA_I}),
        .q_o(pins_q)
    );
    wire strobe_n = pins_q[11];
    wire autofeed_n = pins_q[10];
    wire selin_n = pins_q[9];
    wire init_n = pins_q[8];
    wire [7:0] data = pins_q[7:0];

    logic strobe_n_d;
    logic init_n_d;
    wire strobe_fall = strobe_n_d && !strobe_n;
    wire strobe_rise = !strobe_n_d && strobe_n;
    wire init_fall = init_n_d && !init_n;

    // ------------------------------------------------------------
    // mode selection
    // ------------------------------------------------------------
    // select-in low requests 1284 negotiation (high keeps compatibility); auto-feed picks ecp vs nibble
    logic [1:0] mode;
    wire [1:0] req_mode = selin_n ? pphp_pkg::MODE_COMPAT :
                          (autofeed_n ? pphp_pkg::MODE_NIBBLE : pphp_pkg::MODE_ECP);

    // ------------------------------------------------------------
    // receive word forming
    // ------------------------------------------------------------
    // ecp uses auto-feed as the ninth (command/data) bit
    function automatic logic [pphp_pkg::WORD_W-1:0] form_word(input logic [1:0] m,
            input logic [7:0] d, input logic af_n);
        unique case (m)
            pphp_pkg::MODE_NIBBLE: form_word = {5'h00, d[3:0]};
            pphp_pkg::MODE_ECP: form_word = {af_n, d};
            default: form_word = {1'b0, d};
        endcase
    endfunction

    pphp_pkg::pphp_word_s in_word;
    assign in_word.data = form_word(mode, data, autofeed_n);
    assign in_word.mode = mode;

    logic in_valid;
    logic in_ready;
    logic [$clog2(FIFO_D):0] fifo_count;
    logic [pphp_pkg::WORD_S_W-1:0] fifo_out;
    logic fifo_out_valid;
    // fifo only gives up a word when the output slot really takes it
    wire slot_take = !WORD_VALID_O || WORD_READY_I;

    pphp_fifo #(.W(pphp_pkg::WORD_S_W), .DEPTH(FIFO_D)) u_fifo (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RST_N_I && !INIT_REQ_O),
        .en_i(CE_I),
        .in_valid_i(in_valid),
        .in_ready_o(in_ready),
        .in_data_i(in_word),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(slot_take),
        .out_data_o(fifo_out),
        .count_o(fifo_count)
    );

    // ------------------------------------------------------------
    // buffer space check
    // ------------------------------------------------------------
    function automatic logic [20:0] buf_limit(input logic [1:0] sel);
        unique case (sel)
            pphp_pkg::BUF_100K: buf_limit = 21'(pphp_pkg::BUF_100K_BYTES);
            pphp_pkg::BUF_512K: buf_limit = 21'(pphp_pkg::BUF_512K_BYTES);
            pphp_pkg::BUF_1M: buf_limit = 21'(pphp_pkg::BUF_1M_BYTES);
            default: buf_limit = 21'(pphp_pkg::BUF_1M_BYTES);
        endcase
    endfunction
    // auto: any nonzero free space the engine reports counts as room; the 1M limit plays no part
    wire [20:0] limit = buf_limit(BUF_SEL_I);
    // free space above the limit would wrap the subtraction, so it counts as nothing used
    wire free_over = BUF_FREE_I >= limit;
    wire [20:0] used = (BUF_SEL_I == pphp_pkg::BUF_AUTO || free_over) ? 21'h000000 :
                       limit - BUF_FREE_I;
    wire buf_room = (BUF_FREE_I != 21'h000000) && (used < limit);

    // ------------------------------------------------------------
    // handshake state machine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STORE = 2'b01,
        ST_WAIT_HI = 2'b10,
        ST_ACK = 2'b11
    } pphp_state_e;

    pphp_state_e state;
    pphp_state_e next_state;
    logic [7:0] ack_cnt;
    logic busy_hs;

    wire accept = strobe_fall && SELECT_O;
    assign in_valid = (state == ST_STORE);

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (accept) next_state = ST_STORE;
            ST_STORE: if (in_ready) next_state = ST_WAIT_HI;
            ST_WAIT_HI: if (strobe_n) next_state = ST_ACK;
            ST_ACK: if (ack_cnt == 8'h01) next_state = ST_IDLE;
        endcase
    end

    wire ack_start = (state == ST_WAIT_HI) && strobe_n;
    wire hold_busy = PRINTING_I || ALARM_I || !buf_room || !in_ready;

    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I || INIT_REQ_O) begin
            state <= ST_IDLE;
            ack_cnt <= 8'h00;
        end else if (CE_I) begin
            state <= next_state;
            if (ack_start || (FUNC_DONE_I && state == ST_IDLE)) begin
                ack_cnt <= 8'(pphp_pkg::ACK_CYCLES);
            end else if (ack_cnt != 8'h00) begin
                ack_cnt <= ack_cnt - 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // pin outputs and mode register
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            // match the synchroniser's reset level so no false edge follows reset
            strobe_n_d <= 1'b0;
            init_n_d <= 1'b0;
            mode <= pphp_pkg::MODE_COMPAT;
            busy_hs <= 1'b0;
            ACK_N_O <= 1'b1;
            BUSY_O <= 1'b1;
            PAPER_END_O <= 1'b0;
            SELECT_O <= 1'b0;
            FAULT_N_O <= 1'b1;
            INIT_REQ_O <= 1'b0;
            MODE_O <= pphp_pkg::MODE_COMPAT;
            WORD_VALID_O <= 1'b0;
            WORD_O <= '0;
        end else if (CE_I) begin
            strobe_n_d <= strobe_n;
            init_n_d <= init_n;
            // mode only changes between transfers
            if (state == ST_IDLE && strobe_n) begin
                mode <= req_mode;
            end
            busy_hs <= accept || (state != ST_IDLE && next_state != ST_IDLE);
            ACK_N_O <= !(ack_cnt != 8'h00);
            BUSY_O <= busy_hs || hold_busy || accept || !SELECT_O;
            PAPER_END_O <= PAPER_OUT_I;
            SELECT_O <= ONLINE_I && !ALARM_I;
            FAULT_N_O <= !(PAPER_OUT_I || ALARM_I);
            INIT_REQ_O <= init_fall && INIT_ENABLE_I;
            MODE_O <= mode;
            // output register slot; refills from fifo when empty or taken
            if (slot_take) begin
                WORD_VALID_O <= fifo_out_valid && !INIT_REQ_O;
                WORD_O <= fifo_out;
            end
        end
    end

endmodule

//--- design/pphp_sync.sv
// three-stage synchroniser for host pins
// assumes pins are asynchronous to CLK_SYS_I; a change counts once stages 2 and 3 agree
module pphp_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    wire [W-1:0] agree = ~(s2 ^ s3);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q_o <= '0;
        end else if (en_i) begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
            q_o <= (agree & s3) | (~agree & q_o);
        end
    end
endmodule

//--- dv/pphp_host.sv
// host model: strobes bytes in, paced by busy and acknowledge
// assumes the port's clock; drives only on falling edges
module pphp_host (
    input wire logic clk_i,
    input wire logic busy_i,
    input wire logic ack_n_i,
    output logic strobe_n_o,
    output logic [7:0] data_o,
    output logic autofeed_n_o,
    output logic select_in_n_o,
    output logic init_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int errs = 0;
    initial begin
        strobe_n_o = 1'b1;
        data_o = 8'h00;
        autofeed_n_o = 1'b1;
        select_in_n_o = 1'b1;
        init_n_o = 1'b1;
    end
    // bounded: a missing answer is counted, never hangs
    task automatic wait_sig(input bit use_ack, input logic v);
        int i;
        for (i = 0; (use_ack ? ack_n_i : busy_i) !== v && i < 200; i++) @(negedge clk_i);
        errs += (i == 200);
    endtask
    task automatic set_lines(input logic sin_n, input logic af_n, input logic init_n);
        select_in_n_o <= sin_n;
        autofeed_n_o <= af_n;
        init_n_o <= init_n;
        @(negedge clk_i);
    endtask
    // ninth bit moves with the strobe but returns only after acknowledge, so the idle mode latch briefly sees it
    task automatic send(input logic [7:0] b, input logic af_n);
        logic keep_af;
        keep_af = autofeed_n_o;
        wait_sig(1'b0, 1'b0);
        data_o <= b;
        @(negedge clk_i);
        strobe_n_o <= 1'b0;
        autofeed_n_o <= af_n;
        wait_sig(1'b0, 1'b1);
        strobe_n_o <= 1'b1;
        wait_sig(1'b1, 1'b0);
        wait_sig(1'b1, 1'b1);
        autofeed_n_o <= keep_af;
        data_o <= ~b;
        @(negedge clk_i);
    endtask
endmodule

//--- dv/pphp_port_chk.sv
// checker for pphp_port: status levels, ack width, strobe take, word hold
// assumes CE_I stays high; bound into every pphp_port instance
module pphp_port_chk (
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic STROBE_N_I,
    input wire logic ONLINE_I,
    input wire logic PAPER_OUT_I,
    input wire logic ALARM_I,
    input wire logic WORD_READY_I,
    input wire logic ACK_N_O,
    input wire logic BUSY_O,
    input wire logic PAPER_END_O,
    input wire logic SELECT_O,
    input wire logic FAULT_N_O,
    input wire logic WORD_VALID_O,
    input wire logic [pphp_pkg::WORD_S_W-1:0] WORD_O
);
    localparam int ACKC = pphp_pkg::ACK_CYCLES;
    logic [5:0] low_cnt;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    // counts low samples of acknowledge; the 6-bit count wraps, and a stuck pulse trips the bound check first
    always_ff @(posedge CLK_SYS_I) begin
        low_cnt <= (!RST_N_I || ACK_N_O) ? 6'h00 : low_cnt + 6'h01;
    end
    a_select_level: assert property (
        $past(RST_N_I) |-> SELECT_O == $past(ONLINE_I && !ALARM_I))
        else $error("select level wrong");
    a_fault_level: assert property (
        $past(RST_N_I) |-> FAULT_N_O == !$past(PAPER_OUT_I || ALARM_I))
        else $error("fault level wrong");
    a_paper_end: assert property ($past(RST_N_I) |-> PAPER_END_O == $past(PAPER_OUT_I))
        else $error("paper end wrong");
    a_paper_fault: assert property (PAPER_END_O |-> !FAULT_N_O)
        else $error("paper end without fault");
    a_busy_alarm: assert property ($past(RST_N_I) && $past(ALARM_I) |-> BUSY_O)
        else $error("busy low during alarm");
    a_ack_width: assert property (ACK_N_O && low_cnt != 0 |-> low_cnt == ACKC)
        else $error("ack pulse too short");
    a_ack_bound: assert property (low_cnt <= ACKC)
        else $error("ack pulse too long");
    a_take_busy: assert property ($fell(STROBE_N_I) && SELECT_O |-> ##[1:8] BUSY_O)
        else $error("strobe not answered by busy");
    a_word_hold: assert property (
        WORD_VALID_O && !WORD_READY_I |=> WORD_VALID_O && $stable(WORD_O))
        else $error("word dropped while stalled");
    c_ack: cover property ($fell(ACK_N_O));
    c_word: cover property (WORD_VALID_O && WORD_READY_I);
    c_take: cover property ($fell(STROBE_N_I) && SELECT_O);
endmodule

bind pphp_port pphp_port_chk pphp_port_chk_i (
    .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .STROBE_N_I(STROBE_N_I),
    .ONLINE_I(ONLINE_I), .PAPER_OUT_I(PAPER_OUT_I), .ALARM_I(ALARM_I),
    .WORD_READY_I(WORD_READY_I), .ACK_N_O(ACK_N_O), .BUSY_O(BUSY_O),
    .PAPER_END_O(PAPER_END_O), .SELECT_O(SELECT_O), .FAULT_N_O(FAULT_N_O),
    .WORD_VALID_O(WORD_VALID_O), .WORD_O(WORD_O)
);

//--- dv/pphp_port_tb.sv
// self-checking bench for pphp_port: host model on the pins, engine stand-in on words
// assumes pphp_pkg, the design, pphp_host and pphp_port_chk are compiled first
module pphp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic online = 1'b1;
    logic paper_out = 1'b0;
    logic alarm = 1'b0;
    logic printing = 1'b0;
    logic func_done = 1'b0;
    logic init_en = 1'b1;
    logic [1:0] buf_sel = 2'b11;
    logic [20:0] buf_free = 21'h1FFFFF;
    logic ready = 1'b0;
    logic strobe_n, af_n, sin_n, init_n, ack_n, busy, paper_end, sel, fault_n;
    logic wvalid, init_req, init_seen;
    logic [7:0] data;
    logic [10:0] word;
    logic [1:0] mode;
    int bad_count = 0;
    int check_count = 0;
    always #20 clk = ~clk;
    always @(posedge clk) if (init_req === 1'b1) init_seen <= 1'b1;
    pphp_port pphp_port_i (
        .CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .STROBE_N_I(strobe_n),
        .DATA_I(data), .AUTOFEED_N_I(af_n), .SELECT_IN_N_I(sin_n), .INIT_N_I(init_n),
        .ACK_N_O(ack_n), .BUSY_O(busy), .PAPER_END_O(paper_end), .SELECT_O(sel),
        .FAULT_N_O(fault_n), .ONLINE_I(online), .PAPER_OUT_I(paper_out),
        .ALARM_I(alarm), .PRINTING_I(printing), .FUNC_DONE_I(func_done),
        .INIT_ENABLE_I(init_en), .BUF_SEL_I(buf_sel), .BUF_FREE_I(buf_free),
        .WORD_VALID_O(wvalid), .WORD_READY_I(ready), .WORD_O(word), .MODE_O(mode),
        .INIT_REQ_O(init_req));
    pphp_host pphp_host_i (.clk_i(clk), .busy_i(busy), .ack_n_i(ack_n), .strobe_n_o(strobe_n),
        .data_o(data), .autofeed_n_o(af_n), .select_in_n_o(sin_n), .init_n_o(init_n));
    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic tmo(input bit ok);
        if (!ok) begin
            bad_count++;
            $display("mismatch wait expected done seen timeout");
            results();
        end
    endtask
    // engine takes one word, then stalls a cycle
    task automatic pop(input logic [10:0] exp);
        int i;
        for (i = 0; wvalid !== 1'b1 && i < 100; i++) @(negedge clk);
        tmo(i < 100);
        chk("word", exp, word);
        ready <= 1'b1;
        @(negedge clk);
        ready <= 1'b0;
        @(negedge clk);
    endtask
    task automatic t_status;
        for (int k = 0; k < 16; k++) begin
            {online, alarm, paper_out, printing} = k[3:0];
            repeat (2) @(negedge clk);
            chk("select", online && !alarm, sel);
            chk("fault_n", !(paper_out || alarm), fault_n);
            chk("paper_end", paper_out, paper_end);
            if (alarm || printing) chk("busy", 1'b1, busy);
        end
        {online, alarm, paper_out, printing} = 4'b1000;
        repeat (4) @(negedge clk);
        $display("status test done");
    endtask
    // compatibility sends eight words, seven held in the fifo and one in the output slot, before any word is drained
    task automatic t_modes;
        logic [7:0] b;
        logic a;
        for (int m = 0; m < 3; m++) begin
            pphp_host_i.set_lines(m == 0, m != 2, 1'b1);
            repeat (8) @(negedge clk);
            chk("mode", 11'(m), mode);
            for (int n = 0; n < (m == 0 ? 8 : 2); n++) begin
                pphp_host_i.send(8'hA5 ^ 8'(n * 19), (m != 2) || n == 0);
                tmo(pphp_host_i.errs == 0);
            end
            for (int n = 0; n < (m == 0 ? 8 : 2); n++) begin
                b = 8'hA5 ^ 8'(n * 19);
                a = (m != 2) || n == 0;
                pop(m == 0 ? {1'b0, b, 2'b00} : m == 1 ? {5'h00, b[3:0], 2'b01} : {a, b, 2'b10});
            end
        end
        pphp_host_i.set_lines(1'b1, 1'b1, 1'b1);
        $display("mode test done");
    endtask
    task automatic t_events;
        int i;
        func_done = 1'b1;
        @(negedge clk);
        func_done = 1'b0;
        for (i = 0; ack_n !== 1'b0 && i < 10; i++) @(negedge clk);
        chk("ack_n", 1'b0, ack_n);
        repeat (40) @(negedge clk);
        for (int e = 0; e < 2; e++) begin
            init_en = e[0];
            init_seen = 1'b0;
            pphp_host_i.set_lines(1'b1, 1'b1, 1'b0);
            repeat (6) @(negedge clk);
            pphp_host_i.set_lines(1'b1, 1'b1, 1'b1);
            repeat (4) @(negedge clk);
            chk("init_req", e[0], init_seen);
        end
        for (int s = 0; s < 4; s++) begin
            buf_sel = s[1:0];
            buf_free = 21'h000000;
            repeat (3) @(negedge clk);
            chk("busy", 1'b1, busy);
            buf_free = 21'h1FFFFF;
            repeat (3) @(negedge clk);
            chk("busy", 1'b0, busy);
        end
        $display("event test done");
    endtask
    initial begin
        repeat (10) @(negedge clk);
        chk("reset", 11'h064, {ack_n, busy, paper_end, sel, fault_n, wvalid, init_req});
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        t_status();
        t_modes();
        t_events();
        results();
    end
endmodule
